// file: src/sadc_readout.sv
// Serial readout and conversion sequencer of a successive-approximation converter
`timescale 1ns/1ns
// Function
// - Change output on falling, host samples rising
// - Select fall starts acquisition, enables output
// - Four zeros then result each frame
// - Result is unsigned straight binary
// - First zero driven until first fall
// - Zeros on falls one, two, three
// - MSB on fourth fall, then lower bits
// - Tristate on select rise or done edge
// - Wake when select falls
// - Done at 16/14/12 falling edge, sleep
// - Select rise aborts, sleeps immediately
// - One conversion step per serial clock period
// - Hold input on third falling edge
module sadc_readout
   import sadc_pkg::*;
#(
   parameter int RES_BITS = RES_BITS_DEF
) (
   input  wire logic                clk,           // System clock
   input  wire logic                reset,         // Async reset, high
   input  wire logic                frameSelectN,  // Frame select pin, low active
   input  wire logic                shiftClock,    // Serial clock pin
   input  wire logic [RES_BITS-1:0] sampleValue,   // Digitized input code
   output logic                     resultOut,     // Serial result data
   output logic                     resultOutEn,   // Output driver enable
   output logic                     powerUp,       // Analog core awake
   output logic                     holdActive     // Sampling switch open
);
   localparam int DONE_EDGE = LEAD_ZEROS + RES_BITS;

   logic [SYNC_STAGES-1:0] selSync;
   logic [SYNC_STAGES-1:0] sclkSync;
   logic                   selPrev;
   logic                   sclkPrev;
   logic                   selFall;
   logic                   selRise;
   logic                   sclkFall;
   sadc_state_t            state;
   logic [CNT_W-1:0]       edgeCount;
   logic [RES_BITS-1:0]    shiftReg;
   // Two-entry buffer between converter core and shifter
   logic [RES_BITS-1:0]    bufMem [BUF_DEPTH];
   logic                   bufWr;
   logic                   bufRd;
   logic                   bufFull;
   logic                   bufEmpty;
   logic [1:0]             bufCount;
   logic                   bufWrPtr;
   logic                   bufRdPtr;
   sadc_pin_t              pin;

   // Pins are asynchronous to clk
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         selSync  <= '1;
         sclkSync <= '1;
         selPrev  <= 1'b1;
         sclkPrev <= 1'b1;
      end else begin
         selSync  <= {selSync[0], frameSelectN};
         sclkSync <= {sclkSync[0], shiftClock};
         selPrev  <= selSync[1];
         sclkPrev <= sclkSync[1];
      end
   end

   assign selFall  = selPrev & ~selSync[1];
   assign selRise  = ~selPrev & selSync[1];
   assign sclkFall = sclkPrev & ~sclkSync[1] & ~selSync[1];

   // Sequencer: sleep, track, convert, done
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state     <= SADC_SLEEP;
         edgeCount <= '0;
      end else if (selRise) begin
         state     <= SADC_SLEEP;
         edgeCount <= '0;
      end else if (selFall) begin
         state     <= SADC_TRACK;
         edgeCount <= '0;
      end else if (sclkFall) begin
         case (state)
            SADC_TRACK: begin
               edgeCount <= edgeCount + 1'b1;
               if (edgeCount == CNT_W'(HOLD_EDGE - 1)) begin
                  state <= SADC_CONV;
               end
            end
            SADC_CONV: begin
               edgeCount <= edgeCount + 1'b1;
               if (edgeCount == CNT_W'(DONE_EDGE - 1)) begin
                  state <= SADC_DONE;
               end
            end
            SADC_DONE: state <= SADC_DONE;
            default:   state <= SADC_SLEEP;
         endcase
      end
   end

   // Sample captured at hold point enters buffer
   assign bufWr = sclkFall & ~selRise & ~selFall & (state == SADC_TRACK)
                  & (edgeCount == CNT_W'(HOLD_EDGE - 1)) & ~bufFull;
   // Shifter takes the word on the MSB edge
   assign bufRd = sclkFall & ~selRise & ~selFall & (state == SADC_CONV)
                  & (edgeCount == CNT_W'(LEAD_ZEROS - 1)) & ~bufEmpty;
   assign bufFull  = (bufCount == 2'(BUF_DEPTH));
   assign bufEmpty = (bufCount == 2'h0);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         bufCount <= 2'h0;
         bufWrPtr <= 1'b0;
         bufRdPtr <= 1'b0;
      end else if (selRise) begin
         // Abort flushes stale words
         bufCount <= 2'h0;
         bufWrPtr <= 1'b0;
         bufRdPtr <= 1'b0;
      end else begin
         if (bufWr) begin
            bufWrPtr <= ~bufWrPtr;
         end
         if (bufRd) begin
            bufRdPtr <= ~bufRdPtr;
         end
         bufCount <= bufCount + 2'(bufWr) - 2'(bufRd);
      end
   end

   always_ff @(posedge clk) begin
      if (bufWr) begin
         bufMem[bufWrPtr] <= sampleValue;
      end
   end

   // MSB first after four zeros
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         shiftReg <= '0;
      end else if (bufRd) begin
         shiftReg <= bufMem[bufRdPtr];
      end else if (sclkFall & (state == SADC_CONV)) begin
         shiftReg <= {shiftReg[RES_BITS-2:0], 1'b0};
      end
   end

   always_comb begin
      pin.drive_en = (state == SADC_TRACK) | (state == SADC_CONV);
      pin.bit_out  = 1'b0;
      if (state == SADC_CONV && edgeCount >= CNT_W'(LEAD_ZEROS)) begin
         pin.bit_out = shiftReg[RES_BITS-1];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         resultOut   <= 1'b0;
         resultOutEn <= 1'b0;
         powerUp     <= 1'b0;
         holdActive  <= 1'b0;
      end else begin
         resultOut   <= pin.bit_out;
         resultOutEn <= pin.drive_en;
         powerUp     <= pin.drive_en;
         holdActive  <= (state == SADC_CONV);
      end
   end

   a_done_tristate: assert property (@(posedge clk) disable iff (reset)
      (state == SADC_DONE) |=> !resultOutEn)
      else $error("Output driven after done point");
   a_abort_sleep: assert property (@(posedge clk) disable iff (reset)
      selRise |=> (state == SADC_SLEEP) ##1 !resultOutEn)
      else $error("Abort did not sleep");
   a_start_drive: assert property (@(posedge clk) disable iff (reset)
      selFall |=> (state == SADC_TRACK) ##1 (resultOutEn && !resultOut))
      else $error("Frame start did not enable output");
   a_lead_zeros: assert property (@(posedge clk) disable iff (reset)
      (resultOutEn && $past(edgeCount) < CNT_W'(LEAD_ZEROS)
       && $past(state) != SADC_SLEEP) |-> !resultOut)
      else $error("Leading bit not zero");
   a_hold_edge: assert property (@(posedge clk) disable iff (reset)
      (sclkFall && !selRise && !selFall && state == SADC_TRACK
       && edgeCount == CNT_W'(HOLD_EDGE - 1)) |=> ##1 holdActive)
      else $error("Hold not on third edge");
   a_done_count: assert property (@(posedge clk) disable iff (reset)
      $rose(state == SADC_DONE) |-> edgeCount == CNT_W'(DONE_EDGE))
      else $error("Done at wrong edge count");
   a_done_ignore: assert property (@(posedge clk) disable iff (reset)
      (state == SADC_DONE && !selFall && !selRise) |=> state == SADC_DONE)
      else $error("Left done without new frame");
   a_step_once: assert property (@(posedge clk) disable iff (reset)
      (!sclkFall && !selFall && !selRise) |=> $stable(edgeCount))
      else $error("Step without clock edge");

   // Core power and buffer hand-over checks
   a_wake_select: assert property (@(posedge clk) disable iff (reset)
      selFall |=> ##1 powerUp)
      else $error("Core not awake after frame start");
   a_done_sleep: assert property (@(posedge clk) disable iff (reset)
      (state == SADC_DONE) |=> !powerUp)
      else $error("Core awake after done point");
   a_sleep_idle: assert property (@(posedge clk) disable iff (reset)
      (state == SADC_SLEEP) |=> (!holdActive && !powerUp))
      else $error("Sleep state left core active");
   a_buf_bound: assert property (@(posedge clk) disable iff (reset)
      bufCount <= 2'(BUF_DEPTH))
      else $error("Sample buffer overfilled");
   a_msb_load: assert property (@(posedge clk) disable iff (reset)
      (sclkFall && !selRise && !selFall && state == SADC_CONV
       && edgeCount == CNT_W'(LEAD_ZEROS - 1)) |-> !bufEmpty)
      else $error("No sample ready at MSB edge");
endmodule // sadc_readout

// file: src/sadc_pkg.sv
// Shared constants and types for the serial converter readout block
package sadc_pkg;
   localparam int LEAD_ZEROS     = 4;
   localparam int HOLD_EDGE      = 3;
   localparam int RES_BITS_DEF   = 12;
   localparam int CNT_W          = 5;
   localparam int SYNC_STAGES    = 2;
   localparam int BUF_DEPTH      = 2;
   localparam real CLK_PERIOD_NS = 10.0;
   localparam real MIN_SAMPLE_NS = 643.0;
   localparam int MIN_SAMPLE_CYC = int'($ceil(MIN_SAMPLE_NS / CLK_PERIOD_NS));

   typedef enum logic [1:0] {
      SADC_SLEEP = 2'b00,
      SADC_TRACK = 2'b01,
      SADC_CONV  = 2'b10,
      SADC_DONE  = 2'b11
   } sadc_state_t;

   typedef struct packed {
      logic bit_out;
      logic drive_en;
   } sadc_pin_t;
endpackage

// file: testbench/sadc_host.sv
// Host serial controller model: frames, clocks and samples the result pin
`timescale 1ns/1ns
module sadc_host (
   input  wire logic clk,          // Bench clock, paces the pins
   input  wire logic resultOut,    // Serial result pin
   input  wire logic resultOutEn,  // Result driver enable
   input  wire logic powerUp,      // Core awake flag
   input  wire logic holdActive,   // Hold flag
   input  wire logic resultOut8,   // Result pin of the 8-bit part
   input  wire logic resultOutEn8, // Driver enable of the 8-bit part
   output logic      frameSelectN, // Frame select, low active
   output logic      shiftClock    // Serial clock
);
   logic [31:0] dat, en, hld, pwr, dat8, en8;

   initial begin
      frameSelectN = 1'b1;
      shiftClock   = 1'b1;
   end

   task automatic half(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Sampled late in the high phase, since the pin lags the fall by the sync delay
   task automatic grab();
      dat = {dat[30:0], resultOut};
      en  = {en[30:0], resultOutEn};
      hld = {hld[30:0], holdActive};
      pwr = {pwr[30:0], powerUp};
      dat8 = {dat8[30:0], resultOut8};
      en8  = {en8[30:0], resultOutEn8};
   endtask

   task automatic frame(input int nFalls);
      {dat, en, hld, pwr, dat8, en8} = '0;
      frameSelectN = 1'b0;
      half(50);
      grab();
      for (int i = 0; i < nFalls; i++) begin
         shiftClock = 1'b0;
         half(4);
         shiftClock = 1'b1;
         half(4);
         grab();
      end
      frameSelectN = 1'b1;
      half(8);
   endtask
endmodule // sadc_host

// file: testbench/sadc_readout_tb_top.sv
// Self-checking bench for the serial converter readout block
`timescale 1ns/1ns
module sadc_readout_tb_top;
   logic        clk, reset, frameSelectN, shiftClock;
   logic        resultOut, resultOutEn, powerUp, holdActive;
   logic        resultOut8, resultOutEn8;
   logic [11:0] sampleValue;
   int          fails, checks_done;

   sadc_readout dut (.clk(clk), .reset(reset), .frameSelectN(frameSelectN),
      .shiftClock(shiftClock), .sampleValue(sampleValue), .resultOut(resultOut),
      .resultOutEn(resultOutEn), .powerUp(powerUp), .holdActive(holdActive));
   // Narrow variant shares the pins and takes the top bits of the code
   sadc_readout #(.RES_BITS(8)) dut8 (.clk(clk), .reset(reset),
      .frameSelectN(frameSelectN), .shiftClock(shiftClock), .sampleValue(sampleValue[11:4]),
      .resultOut(resultOut8), .resultOutEn(resultOutEn8), .powerUp(), .holdActive());
   sadc_host host (.clk(clk), .resultOut(resultOut), .resultOutEn(resultOutEn),
      .powerUp(powerUp), .holdActive(holdActive), .resultOut8(resultOut8),
      .resultOutEn8(resultOutEn8), .frameSelectN(frameSelectN),
      .shiftClock(shiftClock));

   task automatic check(input string what, input logic [31:0] exp, got);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic run_frame(input logic [11:0] v, input int n);
      sampleValue = v;
      host.frame(n);
      check("data", {19'h0, v, 1'b0} << (n - 16), host.dat);
      check("enable", 32'h1fffe << (n - 16), host.en);
      check("hold", 32'h1, (host.hld >> (n - 3)) & 32'h3);
      check("awake", 32'h1, (host.pwr >> n) & 32'h1);
      check("asleep", 32'h0, {31'h0, powerUp});
      check("data8", {19'h0, v[11:4], 5'h0} << (n - 16), host.dat8);
      check("enable8", 32'h1ffe0 << (n - 16), host.en8);
   endtask

   task automatic test_init();
      host.frame(0);
      check("idle enable", 32'h0, {31'h0, resultOutEn});
      $display("test_init done");
   endtask

   task automatic test_codes();
      logic [11:0] codes [5] = '{12'h000, 12'h800, 12'hfff, 12'h7ff, 12'ha5c};
      foreach (codes[i]) run_frame(codes[i], 16);
      $display("test_codes done");
   endtask

   task automatic test_overrun();
      run_frame(12'h3c6, 18);
      run_frame(12'h001, 16);
      $display("test_overrun done");
   endtask

   task automatic test_abort();
      sampleValue = 12'h5a5;
      host.frame(6);
      check("abort data", 32'h2, host.dat);
      check("abort enable", 32'h0, {31'h0, resultOutEn});
      check("abort awake", 32'h0, {31'h0, powerUp});
      run_frame(12'hc3a, 16);
      $display("test_abort done");
   endtask

   task automatic give_verdict();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      reset = 1'b1;
      sampleValue = 12'h0;
      repeat (8) @(posedge clk);
      #1 reset = 1'b0;
      repeat (4) @(posedge clk);
      test_init();
      test_codes();
      test_overrun();
      test_abort();
      give_verdict();
   end

   // Hang guard
   initial begin
      #200000;
      fails++;
      give_verdict();
   end
endmodule // sadc_readout_tb_top
